//--- mpc_pkg.sv
package mpc_pkg;

	// ----------------------------------------------------------------
	// register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [14:0] ADDR_BIAS     = 15'h0032;
	localparam logic [14:0] ADDR_CHB_TERM = 15'h0039;
	localparam logic [14:0] ADDR_DLY_HI   = 15'h003C;
	localparam logic [14:0] ADDR_DLY_LO   = 15'h005A;
	localparam logic [7:0]  REG_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIAS_HIZ_BIT = 5;
	localparam int CHB_GATE_BIT = 1;
	localparam int TERM_OFF_BIT = 0;
	localparam int DLY_EN_BIT   = 6;
	localparam int DLY_HI_MSB   = 1;
	localparam int DLY_HI_LSB   = 0;
	localparam int DLY_LO_MSB   = 7;
	localparam int DLY_LO_LSB   = 5;

	// ----------------------------------------------------------------
	// serial frame: rw bit, 15 address bits, 8 data bits
	// ----------------------------------------------------------------
	localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
	localparam logic [4:0] ADDR_LAST_BIT  = 5'h0F;
	localparam logic [4:0] FRAME_DONE     = 5'h18;

	// ----------------------------------------------------------------
	// delay code map, in picoseconds
	// ----------------------------------------------------------------
	localparam int         DLY_FIRST_PS   = 175;
	localparam int         DLY_STEP_PS    = 25;
	localparam logic [4:0] DLY_CODE_FIRST = 5'h08;
	localparam logic [4:0] DLY_CODE_LAST  = 5'h03;
	localparam logic [8:0] DLY_NONE_PS    = 9'h000;

	typedef struct packed {
		logic       bias_high_impedance_select;
		logic       chan_b_powerdown_gate;
		logic       sync_input_termination_off;
		logic       ref_delay_enable;
		logic [4:0] ref_delay_code;
	} mpc_cfg_t;

endpackage

//--- mpc_regs.sv
module mpc_regs (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// serial configuration port
	input  wire logic             spi_sclk,
	input  wire logic             spi_sen_n,
	input  wire logic             spi_sdin,
	output logic                  spi_sdout,
	output logic                  spi_sdout_oe_n,
	// power-down bit from the neighbouring register
	input  wire logic             chan_b_powerdown,
	// configuration outputs
	output mpc_pkg::mpc_cfg_t     cfg,
	output logic                  chan_b_powerdown_active,
	output logic [8:0]            ref_delay_ps
);

	logic        s_sclk;
	logic        s_sen_n;
	logic        s_sdin;
	logic        sclk_d_reg;
	logic        sclk_rise;
	logic        sclk_fall;
	logic [4:0]  bit_cnt_reg;
	logic [23:0] shift_in_reg;
	logic        wr_fire;
	logic [14:0] wr_addr;
	logic [7:0]  wr_data;
	logic        rd_load;
	logic [14:0] rd_addr;
	logic [7:0]  rd_data;
	logic [7:0]  rd_shift_reg;
	logic        rd_active_reg;
	logic        sdout_oe_n_reg;
	logic        spi_sdout_reg;
	logic        bias_reg;
	logic        chb_gate_reg;
	logic        term_off_reg;
	logic        dly_en_reg;
	logic [1:0]  dly_hi_reg;
	logic [2:0]  dly_lo_reg;
	logic        chb_pd_reg;
	logic [8:0]  dly_ps_reg;
	logic [8:0]  dly_ps_next;
	logic [4:0]  dly_code;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	mpc_sync #(
		.W         (3),
		.RESET_VAL (3'h2)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({spi_sclk, spi_sen_n, spi_sdin}),
		.sync_out ({s_sclk, s_sen_n, s_sdin})
	);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= s_sclk;
		end
	end

	assign sclk_rise = s_sclk & ~sclk_d_reg & ~s_sen_n;
	assign sclk_fall = ~s_sclk & sclk_d_reg & ~s_sen_n;

	// ----------------------------------------------------------------
	// frame shifter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bit_cnt_reg  <= 5'h00;
			shift_in_reg <= 24'h000000;
		end else if (s_sen_n) begin
			bit_cnt_reg  <= 5'h00;
		end else if (sclk_rise && bit_cnt_reg != mpc_pkg::FRAME_DONE) begin
			bit_cnt_reg  <= bit_cnt_reg + 5'h01;
			shift_in_reg <= {shift_in_reg[22:0], s_sdin};
		end
	end

	// first frame bit high means read
	assign wr_fire = sclk_rise && bit_cnt_reg == mpc_pkg::FRAME_LAST_BIT && !shift_in_reg[22];
	assign wr_addr = shift_in_reg[21:7];
	assign wr_data = {shift_in_reg[6:0], s_sdin};
	assign rd_load = sclk_rise && bit_cnt_reg == mpc_pkg::ADDR_LAST_BIT && shift_in_reg[14];
	assign rd_addr = {shift_in_reg[13:0], s_sdin};

	// ----------------------------------------------------------------
	// register writes; reserved bits are not stored
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bias_reg <= mpc_pkg::REG_RESET[mpc_pkg::BIAS_HIZ_BIT];
		end else if (wr_fire && wr_addr == mpc_pkg::ADDR_BIAS) begin
			bias_reg <= wr_data[mpc_pkg::BIAS_HIZ_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chb_gate_reg <= mpc_pkg::REG_RESET[mpc_pkg::CHB_GATE_BIT];
			term_off_reg <= mpc_pkg::REG_RESET[mpc_pkg::TERM_OFF_BIT];
		end else if (wr_fire && wr_addr == mpc_pkg::ADDR_CHB_TERM) begin
			chb_gate_reg <= wr_data[mpc_pkg::CHB_GATE_BIT];
			term_off_reg <= wr_data[mpc_pkg::TERM_OFF_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dly_en_reg <= mpc_pkg::REG_RESET[mpc_pkg::DLY_EN_BIT];
			dly_hi_reg <= mpc_pkg::REG_RESET[mpc_pkg::DLY_HI_MSB:mpc_pkg::DLY_HI_LSB];
		end else if (wr_fire && wr_addr == mpc_pkg::ADDR_DLY_HI) begin
			dly_en_reg <= wr_data[mpc_pkg::DLY_EN_BIT];
			dly_hi_reg <= wr_data[mpc_pkg::DLY_HI_MSB:mpc_pkg::DLY_HI_LSB];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dly_lo_reg <= mpc_pkg::REG_RESET[mpc_pkg::DLY_LO_MSB:mpc_pkg::DLY_LO_LSB];
		end else if (wr_fire && wr_addr == mpc_pkg::ADDR_DLY_LO) begin
			dly_lo_reg <= wr_data[mpc_pkg::DLY_LO_MSB:mpc_pkg::DLY_LO_LSB];
		end
	end

	// ----------------------------------------------------------------
	// readback; reserved bits read zero
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 8'h00;
		case (rd_addr)
			mpc_pkg::ADDR_BIAS:     rd_data[mpc_pkg::BIAS_HIZ_BIT] = bias_reg;
			mpc_pkg::ADDR_CHB_TERM: begin
				rd_data[mpc_pkg::CHB_GATE_BIT] = chb_gate_reg;
				rd_data[mpc_pkg::TERM_OFF_BIT] = term_off_reg;
			end
			mpc_pkg::ADDR_DLY_HI:   begin
				rd_data[mpc_pkg::DLY_EN_BIT] = dly_en_reg;
				rd_data[mpc_pkg::DLY_HI_MSB:mpc_pkg::DLY_HI_LSB] = dly_hi_reg;
			end
			mpc_pkg::ADDR_DLY_LO:   rd_data[mpc_pkg::DLY_LO_MSB:mpc_pkg::DLY_LO_LSB] = dly_lo_reg;
			default:                rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_shift_reg   <= 8'h00;
			rd_active_reg  <= 1'b0;
			sdout_oe_n_reg <= 1'b1;
			spi_sdout_reg  <= 1'b0;
		end else if (s_sen_n) begin
			rd_active_reg  <= 1'b0;
			sdout_oe_n_reg <= 1'b1;
		end else if (rd_load) begin
			rd_shift_reg   <= rd_data;
			rd_active_reg  <= 1'b1;
			sdout_oe_n_reg <= 1'b0;
		end else if (sclk_fall && rd_active_reg) begin
			spi_sdout_reg  <= rd_shift_reg[7];
			rd_shift_reg   <= {rd_shift_reg[6:0], 1'b0};
		end
	end

	assign spi_sdout      = spi_sdout_reg;
	assign spi_sdout_oe_n = sdout_oe_n_reg;

	// ----------------------------------------------------------------
	// derived controls
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			chb_pd_reg <= 1'b0;
		end else begin
			chb_pd_reg <= chb_gate_reg & chan_b_powerdown;
		end
	end

	assign dly_code = {dly_hi_reg, dly_lo_reg};

	// each decrement below the first code adds one step
	always_comb begin
		dly_ps_next = mpc_pkg::DLY_NONE_PS;
		if (dly_en_reg && dly_code <= mpc_pkg::DLY_CODE_FIRST
		    && dly_code >= mpc_pkg::DLY_CODE_LAST) begin
			dly_ps_next = 9'(mpc_pkg::DLY_FIRST_PS + mpc_pkg::DLY_STEP_PS
			              * (int'(mpc_pkg::DLY_CODE_FIRST) - int'(dly_code)));
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dly_ps_reg <= mpc_pkg::DLY_NONE_PS;
		end else begin
			dly_ps_reg <= dly_ps_next;
		end
	end

	assign chan_b_powerdown_active = chb_pd_reg;
	assign ref_delay_ps            = dly_ps_reg;
	assign cfg = '{
		bias_high_impedance_select: bias_reg,
		chan_b_powerdown_gate:      chb_gate_reg,
		sync_input_termination_off: term_off_reg,
		ref_delay_enable:           dly_en_reg,
		ref_delay_code:             dly_code
	};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_bias_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fire && wr_addr == mpc_pkg::ADDR_BIAS |=> cfg.bias_high_impedance_select
		== $past(wr_data[5]))
		else $error("bias select did not follow write");

	chk_chb_ignored: assert property (@(posedge sys_clk) disable iff (rst)
		!chb_gate_reg |=> !chan_b_powerdown_active)
		else $error("channel B powered down while ungated");

	chk_chb_powerdown: assert property (@(posedge sys_clk) disable iff (rst)
		chb_gate_reg && chan_b_powerdown |=> chan_b_powerdown_active)
		else $error("gated power-down did not take effect");

	chk_term_write: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fire && wr_addr == mpc_pkg::ADDR_CHB_TERM |=> cfg.sync_input_termination_off
		== $past(wr_data[0]))
		else $error("termination control did not follow write");

	chk_delay_off: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg.ref_delay_enable |=> ref_delay_ps == 9'h000)
		else $error("delay added while disabled");

	chk_code_split: assert property (@(posedge sys_clk) disable iff (rst)
		wr_fire && wr_addr == mpc_pkg::ADDR_DLY_LO |=> cfg.ref_delay_code[2:0]
		== $past(wr_data[7:5]) && $stable(cfg.ref_delay_code[4:3]))
		else $error("low delay code bits misplaced");

	chk_first_step: assert property (@(posedge sys_clk) disable iff (rst)
		cfg.ref_delay_enable && cfg.ref_delay_code == 5'h08 |=> ref_delay_ps == 9'h0AF)
		else $error("first delay step is not 175 ps");

	chk_last_step: assert property (@(posedge sys_clk) disable iff (rst)
		cfg.ref_delay_enable && cfg.ref_delay_code == 5'h03 |=> ref_delay_ps == 9'h12C)
		else $error("code 00011 is not 300 ps");

endmodule

//--- mpc_sync.sv
module mpc_sync #(
	parameter int               W         = 1,
	parameter logic [W-1:0]     RESET_VAL = '0
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// ----------------------------------------------------------------
	// two-stage synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

//--- test_master_page_sysref_delay_config.sv
module test_master_page_sysref_delay_config;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------------------------------
	// stimulus and dut
	// ----------------------------------------------------------------
	logic              sys_clk          = 1'h0;
	logic              rst              = 1'h1;
	logic              spi_sclk         = 1'h0;
	logic              spi_sen_n        = 1'h1;
	logic              spi_sdin         = 1'h0;
	logic              chan_b_powerdown = 1'h0;
	logic              spi_sdout;
	logic              spi_sdout_oe_n;
	logic              chan_b_powerdown_active;
	logic [8:0]        ref_delay_ps;
	mpc_pkg::mpc_cfg_t cfg;
	int                fails            = 0;
	int                tests_run        = 0;

	always #5 sys_clk = ~sys_clk;

	mpc_regs u_dut (
		.sys_clk                 (sys_clk),
		.rst                     (rst),
		.spi_sclk                (spi_sclk),
		.spi_sen_n               (spi_sen_n),
		.spi_sdin                (spi_sdin),
		.spi_sdout               (spi_sdout),
		.spi_sdout_oe_n          (spi_sdout_oe_n),
		.chan_b_powerdown        (chan_b_powerdown),
		.cfg                     (cfg),
		.chan_b_powerdown_active (chan_b_powerdown_active),
		.ref_delay_ps            (ref_delay_ps)
	);

	// ----------------------------------------------------------------
	// compare, serial frame, verdict
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// 24 bit frame, msb first; read data sampled at the rise after each fall
	task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] d,
			output logic [7:0] q);
		logic [23:0] f;
		f = {rw, a, d};
		q = 8'h00;
		spi_sen_n <= 1'h0;
		cycles(5);
		for (int i = 23; i >= 0; i--) begin
			spi_sclk <= 1'h0;
			spi_sdin <= (rw && i < 8) ? 1'h0 : f[i];
			cycles(5);
			if (rw && i < 8)
				q[i] = spi_sdout;
			if (rw && i == 0)
				check("oe_n in read", 16'(spi_sdout_oe_n), 16'h0000);
			spi_sclk <= 1'h1;
			cycles(5);
		end
		spi_sen_n <= 1'h1;
		spi_sclk  <= 1'h0;
		cycles(6);
	endtask

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [7:0] q;
		frame(1'h0, a, d, q);
	endtask

	task automatic rd(input logic [14:0] a, input logic [7:0] exp);
		logic [7:0] q;
		frame(1'h1, a, 8'h00, q);
		check("read data", 16'(q), 16'(exp));
		check("oe_n idle", 16'(spi_sdout_oe_n), 16'h0001);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		logic [4:0] code;
		cycles(6);
		rst <= 1'h0;
		cycles(4);
		check("cfg reset", 16'(cfg), 16'h0000);
		wr(15'h0012, 8'h04);
		rd(mpc_pkg::ADDR_BIAS, 8'h00);
		rd(mpc_pkg::ADDR_CHB_TERM, 8'h00);
		rd(mpc_pkg::ADDR_DLY_HI, 8'h00);
		rd(mpc_pkg::ADDR_DLY_LO, 8'h00);
		// reserved bits written zero, bias bit kept
		wr(mpc_pkg::ADDR_BIAS, 8'h20);
		check("bias bit", 16'(cfg.bias_high_impedance_select), 16'h0001);
		rd(mpc_pkg::ADDR_BIAS, 8'h20);
		// gate and termination, with the always-one bits
		chan_b_powerdown <= 1'h1;
		wr(mpc_pkg::ADDR_CHB_TERM, 8'h53);
		check("term off", 16'(cfg.sync_input_termination_off), 16'h0001);
		check("pd active", 16'(chan_b_powerdown_active), 16'h0001);
		rd(mpc_pkg::ADDR_CHB_TERM, 8'h03);
		chan_b_powerdown <= 1'h0;
		cycles(3);
		check("pd released", 16'(chan_b_powerdown_active), 16'h0000);
		chan_b_powerdown <= 1'h1;
		wr(mpc_pkg::ADDR_CHB_TERM, 8'h50);
		check("pd ungated", 16'(chan_b_powerdown_active), 16'h0000);
		check("term on", 16'(cfg.sync_input_termination_off), 16'h0000);
		// every listed delay code
		for (int c = 8; c >= 3; c--) begin
			code = 5'(c);
			wr(mpc_pkg::ADDR_DLY_HI, {2'h1, 4'h0, code[4:3]});
			wr(mpc_pkg::ADDR_DLY_LO, {code[2:0], 5'h00});
			check("code", 16'(cfg.ref_delay_code), 16'(code));
			check("delay ps", 16'(ref_delay_ps), 16'(175 + 25 * (8 - c)));
			rd(mpc_pkg::ADDR_DLY_LO, {code[2:0], 5'h00});
		end
		rd(mpc_pkg::ADDR_DLY_HI, 8'h40);
		check("code 3 ps", 16'(ref_delay_ps), 16'h012C);
		wr(mpc_pkg::ADDR_DLY_HI, 8'h00);
		check("disabled ps", 16'(ref_delay_ps), 16'h0000);
		// unmapped address
		wr(15'h0033, 8'hFF);
		rd(15'h0033, 8'h00);
		check("cfg after unmapped", 16'(cfg), 16'h0103);
		// reset in mid-run
		wr(mpc_pkg::ADDR_BIAS, 8'h20);
		rst <= 1'h1;
		cycles(2);
		check("cfg second reset", 16'(cfg), 16'h0000);
		check("ps second reset", 16'(ref_delay_ps), 16'h0000);
		rst <= 1'h0;
		cycles(4);
		rd(mpc_pkg::ADDR_BIAS, 8'h00);
		summarize();
	end

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (60000) @(posedge sys_clk);
		fails++;
		summarize();
	end
endmodule
